// ---- shared/pcd_pkg.sv ----
package pcd_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PORT_C_DATA = 8'h07;
    localparam logic [7:0] IDX_PORT_D_DATA = 8'h08;
    localparam logic [7:0] IDX_PORT_C_DIR  = 8'h87;
    localparam logic [7:0] IDX_PORT_D_DIR  = 8'h88;
    localparam logic [7:0] IDX_PORT_E_STAT = 8'h89;
    localparam int         ADR_W           = 10;
    localparam int         IDX_LSB         = 2;
    localparam int         PORT_W          = 8;

    // reset values
    localparam logic [7:0] RST_DATA   = 8'h00;
    localparam logic [7:0] RST_DIR    = 8'hff;
    localparam logic [2:0] RST_E_DIR  = 3'h7;
    localparam logic       RST_PSP    = 1'b0;

    // fields of the port e direction and slave status register
    localparam int BIT_IN_FULL  = 7;
    localparam int BIT_OUT_FULL = 6;
    localparam int BIT_IN_OVF   = 5;
    localparam int BIT_PSP_MODE = 4;
    localparam int E_DIR_W      = 3;

    // port c pin functions
    localparam int PC_TMR_OSC_OUT = 0;
    localparam int PC_TMR_OSC_IN  = 1;
    localparam int PC_CCP_ONE     = 2;
    localparam int PC_SSP_CLK     = 3;
    localparam int PC_SSP_DIN     = 4;
    localparam int PC_SSP_DOUT    = 5;
    localparam int PC_USART_TXCK  = 6;
    localparam int PC_USART_RXDT  = 7;

    localparam logic [31:0] WB_ZERO = 32'h0000_0000;
endpackage : pcd_pkg

// ---- hdl/pcd_pin_cell.sv ----
`timescale 1ns/10ps
// one pad: port latch or alternate source, with matching enable
module pcd_pin_cell (
    input  wire logic latch,
    input  wire logic dir_in,
    input  wire logic alt_sel,
    input  wire logic alt_out,
    input  wire logic alt_oe,
    output logic      pad_o,
    output logic      pad_oe
);
    // alternate enable counts only while the alternate owns the pin
    always_comb begin
        if (alt_sel) begin
            pad_o  = alt_out;
            pad_oe = alt_oe;
        end else begin
            pad_o  = latch;
            pad_oe = ~dir_in;  // direction bit set means input
        end
    end
endmodule : pcd_pin_cell

// ---- hdl/pcd_wb_front.sv ----
`timescale 1ns/10ps
// classic wishbone handshake: ack one cycle after the request edge
module pcd_wb_front
    import pcd_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    output logic                  wb_ack_o,
    output logic                  rd_take,
    output logic                  wr_take,
    output logic [7:0]            idx
);
    logic req;

    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
    // read data is latched as ack rises, held while ack stands
    assign rd_take = req & ~wb_ack_o & ~wb_we_i;
    // writes land on the edge that also sees ack high
    assign wr_take = req & wb_ack_o & wb_we_i;

    // ack drops the cycle after it was given, even if stb stays up
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end
endmodule : pcd_wb_front

// ---- hdl/pcd_port_cd.sv ----
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
// Operation
// - per-pin select picks latch or peripheral output
// - peripheral enable counts only when selected
// - C0 is io or timer osc/clock
// - C1 is io, timer osc in, ccp two
// - C2 is io or ccp one
// - C3 may carry serial port clock
// - C4 may carry serial data in/line
// - C5 is io or serial data out
// - C6 is io, usart transmit or clock
// - C7 is io, usart receive or data
// - port D eight pins, own direction each
// - mode bit four makes D parallel port
// - D pin n carries data bit n
// - direction set floats pin, clear drives latch
// - slave mode ignores D direction register
module pcd_port_cd
    import pcd_pkg::*;
#(
    parameter int W = PORT_W
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [W-1:0]     pc_pad_i,
    output logic [W-1:0]          pc_pad_o,
    output logic [W-1:0]          pc_pad_oe,
    input  wire logic [W-1:0]     pd_pad_i,
    output logic [W-1:0]          pd_pad_o,
    output logic [W-1:0]          pd_pad_oe,
    input  wire logic [W-1:0]     pc_periph_sel,
    input  wire logic [W-1:0]     pc_periph_out,
    input  wire logic [W-1:0]     pc_periph_oe,
    input  wire logic             slave_drive_en,
    input  wire logic             slave_input_full,
    input  wire logic             slave_output_full,
    input  wire logic             slave_input_overflow,
    output logic                  slave_overflow_clear,
    output logic                  parallel_slave_mode_select,
    output logic [E_DIR_W-1:0]    port_e_dir,
    output logic [W-1:0]          slave_bus_data,
    output logic                  timer_ext_clock_input,
    output logic                  timer_osc_input,
    output logic                  capture_compare_pwm_two,
    output logic                  capture_compare_pwm_one,
    output logic                  serial_clock_in,
    output logic                  serial_port_data_in,
    output logic                  usart_clock_in,
    output logic                  usart_receive_in
);
    logic [W-1:0] pc_latch;
    logic [W-1:0] pd_latch;
    logic [W-1:0] pc_dir;
    logic [W-1:0] pd_dir;
    logic [W-1:0] pc_pins;
    logic [W-1:0] pd_pins;
    logic         rd_take;
    logic         wr_take;
    logic [7:0]   idx;
    logic         wr_lane;
    logic [7:0]   wr_byte;
    logic [7:0]   next_rdata;
    logic [7:0]   e_stat;

    // bus handshake lives in its own small module
    pcd_wb_front u_front (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_ack_o (wb_ack_o),
        .rd_take  (rd_take),
        .wr_take  (wr_take),
        .idx      (idx)
    );

    // only the low byte lane holds register bits
    assign wr_lane = wr_take & wb_sel_i[0];
    assign wr_byte = wb_dat_i[7:0];

    // output latches; power-up contents are undefined, zero is chosen
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_latch <= RST_DATA;
            pd_latch <= RST_DATA;
        end else if (wr_lane) begin
            if (idx == IDX_PORT_C_DATA)
                pc_latch <= wr_byte;
            if (idx == IDX_PORT_D_DATA)
                pd_latch <= wr_byte;
        end
    end

    // direction registers, all pins inputs after reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_dir <= RST_DIR;
            pd_dir <= RST_DIR;
        end else if (wr_lane) begin
            if (idx == IDX_PORT_C_DIR)
                pc_dir <= wr_byte;
            if (idx == IDX_PORT_D_DIR)
                pd_dir <= wr_byte;
        end
    end

    // mode bit and port e direction; status bits are read only here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            parallel_slave_mode_select <= RST_PSP;
            port_e_dir                 <= RST_E_DIR;
        end else if (wr_lane && idx == IDX_PORT_E_STAT) begin
            parallel_slave_mode_select <= wr_byte[BIT_PSP_MODE];
            port_e_dir                 <= wr_byte[E_DIR_W-1:0];
        end
    end

    // overflow is cleared by software writing zero to its bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            slave_overflow_clear <= 1'b0;
        end else begin
            slave_overflow_clear <= wr_lane && idx == IDX_PORT_E_STAT
                                    && !wr_byte[BIT_IN_OVF];
        end
    end

    // pins are synchronous; one flop gives clean read data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_pins <= RST_DATA;
            pd_pins <= RST_DATA;
        end else begin
            pc_pins <= pc_pad_i;
            pd_pins <= pd_pad_i;
        end
    end

    // status view; bit three reads as zero
    always_comb begin
        e_stat                = {5'h00, port_e_dir};
        e_stat[BIT_IN_FULL]   = slave_input_full;
        e_stat[BIT_OUT_FULL]  = slave_output_full;
        e_stat[BIT_IN_OVF]    = slave_input_overflow;
        e_stat[BIT_PSP_MODE]  = parallel_slave_mode_select;
    end

    // read mux; unmapped indices answer zero
    always_comb begin
        unique case (idx)
            IDX_PORT_C_DATA: next_rdata = pc_pins;
            IDX_PORT_D_DATA: next_rdata = pd_pins;
            IDX_PORT_C_DIR:  next_rdata = pc_dir;
            IDX_PORT_D_DIR:  next_rdata = pd_dir;
            IDX_PORT_E_STAT: next_rdata = e_stat;
            default:         next_rdata = 8'h00;
        endcase
    end

    // read data held from ack until the next read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_dat_o <= WB_ZERO;
        end else if (rd_take) begin
            wb_dat_o <= {24'h000000, next_rdata};
        end
    end

    // port c cells: select chooses latch or peripheral per pin
    // port d cells: slave mode hands the enable to the slave logic,
    // so the direction register has no say there
    for (genvar i = 0; i < W; i++) begin : g_pin
        pcd_pin_cell u_pc (
            .latch   (pc_latch[i]),
            .dir_in  (pc_dir[i]),
            .alt_sel (pc_periph_sel[i]),
            .alt_out (pc_periph_out[i]),
            .alt_oe  (pc_periph_oe[i]),
            .pad_o   (pc_pad_o[i]),
            .pad_oe  (pc_pad_oe[i])
        );
        pcd_pin_cell u_pd (
            .latch   (pd_latch[i]),
            .dir_in  (pd_dir[i]),
            .alt_sel (parallel_slave_mode_select),
            .alt_out (pd_latch[i]),
            .alt_oe  (slave_drive_en),
            .pad_o   (pd_pad_o[i]),
            .pad_oe  (pd_pad_oe[i])
        );
    end

    // slave logic sees the pin byte, pin n as bit n
    assign slave_bus_data = pd_pins;

    // peripheral inputs taken from sampled port c pins
    assign timer_ext_clock_input   = pc_pins[PC_TMR_OSC_OUT];
    assign timer_osc_input         = pc_pins[PC_TMR_OSC_IN];
    assign capture_compare_pwm_two = pc_pins[PC_TMR_OSC_IN];
    assign capture_compare_pwm_one = pc_pins[PC_CCP_ONE];
    assign serial_clock_in         = pc_pins[PC_SSP_CLK];
    assign serial_port_data_in     = pc_pins[PC_SSP_DIN];
    assign usart_clock_in          = pc_pins[PC_USART_TXCK];
    assign usart_receive_in        = pc_pins[PC_USART_RXDT];
    // outputs on bits 0,1,2,3,4,5,6,7 use the generic mux

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_wr_c_data;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
        && idx == IDX_PORT_C_DATA;
    endsequence

    sequence s_rd_pins_d;
        s_req ##0 (!wb_we_i && idx == IDX_PORT_D_DATA);
    endsequence

    a_ack_one_late: assert property (
        s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");

    a_c_latch_drive: assert property (
        s_wr_c_data ##1 !pc_periph_sel[0]
        |-> pc_pad_o[0] == $past(wb_dat_i[0]))
        else $error("port c pin not driven from latch");

    a_c_periph_mux: assert property (
        pc_periph_sel[PC_SSP_DOUT]
        |-> pc_pad_o[PC_SSP_DOUT] == pc_periph_out[PC_SSP_DOUT])
        else $error("serial data out not routed");

    a_c_periph_oe: assert property (
        (pc_periph_oe & ~pc_periph_sel) != '0
        |-> (pc_pad_oe & ~pc_periph_sel) == (~pc_dir & ~pc_periph_sel))
        else $error("peripheral enable leaked while deselected");

    a_c_input_float: assert property (
        (pc_dir == 8'hff && pc_periph_sel == 8'h00) |-> pc_pad_oe == 8'h00)
        else $error("input pin is driven");

    a_d_dir_write: assert property (
        (s_req ##0 (wb_we_i && wb_sel_i[0] && idx == IDX_PORT_D_DIR
        && !parallel_slave_mode_select)) ##1 wb_ack_o ##1
        !parallel_slave_mode_select |-> pd_pad_oe == ~$past(wb_dat_i[7:0]))
        else $error("port d direction write lost");

    a_d_slave_mode: assert property (
        (wr_lane && idx == IDX_PORT_E_STAT)
        |=> parallel_slave_mode_select == $past(wb_dat_i[BIT_PSP_MODE]))
        else $error("mode bit not taken");

    a_d_dir_ignored: assert property (
        parallel_slave_mode_select |-> pd_pad_oe == {W{slave_drive_en}})
        else $error("direction register acts in slave mode");

    a_d_bit_order: assert property (
        parallel_slave_mode_select |-> pd_pad_o == pd_latch)
        else $error("slave data bits out of order");

    a_d_read_pins: assert property (
        (s_rd_pins_d ##0 $stable(pd_pad_i)) ##1 $stable(pd_pad_i)
        |=> wb_dat_o[7:0] == $past(pd_pad_i, 2))
        else $error("port d read does not show pins");

    // pin samples are forced to zero in reset, so skip the first edge
    a_c_timer_in: assert property (
        !$past(rst)
        |-> timer_ext_clock_input == $past(pc_pad_i[PC_TMR_OSC_OUT]))
        else $error("timer clock input not sampled");

    a_c_alt_enable: assert property (
        (pc_pad_oe & pc_periph_sel) == (pc_periph_oe & pc_periph_sel))
        else $error("selected peripheral enable not used");

    a_c_serial_in: assert property (
        !$past(rst)
        |-> serial_port_data_in == $past(pc_pad_i[PC_SSP_DIN]))
        else $error("serial data input not sampled");

    a_d_gpio_drive: assert property (
        !parallel_slave_mode_select
        |-> pd_pad_oe == ~pd_dir && pd_pad_o == pd_latch)
        else $error("port d pins not under direction control");

    a_d_slave_data: assert property (
        !$past(rst) |-> slave_bus_data == $past(pd_pad_i))
        else $error("slave data byte not taken from pins");

endmodule : pcd_port_cd

// ---- test/pcd_pin_world.sv ----
`timescale 1ns/10ps
// pins outside the chip: device drive wins, else the outside driver,
// else the board pull-up, so a released pin never shows a stale level
module pcd_pin_world (
    input  wire logic [7:0] pad_o,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] ext_val,
    input  wire logic       ext_en,
    output logic [7:0]      pad_i
);
    // per-pin resolution of the shared wire
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i]) begin
                pad_i[i] = pad_o[i];
            end else begin
                pad_i[i] = ext_en ? ext_val[i] : 1'b1;
            end
        end
    end
endmodule : pcd_pin_world

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench
    import pcd_pkg::*;
;
    logic clk_sys = 0, rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0, wb_dat_o;
    logic wb_ack_o, drv_en = 0, in_full = 0, out_full = 0, in_ovf = 0;
    logic [7:0] pc_i, pc_o, pc_oe, pd_i, pd_o, pd_oe, sbus;
    logic [7:0] sel = 8'h00, pout = 8'h00, poe = 8'h00;
    logic [7:0] c_ext = 8'h00, d_ext = 8'h00, q;
    logic c_en = 0, d_en = 0, clr, mode;
    logic [2:0] edir;
    logic [7:0] fn;
    int n_mismatch = 0, samples_checked = 0, n_clr = 0;

    always #5 clk_sys = ~clk_sys;
    // count overflow-clear pulses seen on the status interface
    always @(posedge clk_sys) if (clr === 1'b1) n_clr++;

    pcd_port_cd pcd_port_cd_i (.clk_sys(clk_sys), .rst(rst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_pad_i(pc_i),
        .pc_pad_o(pc_o), .pc_pad_oe(pc_oe), .pd_pad_i(pd_i),
        .pd_pad_o(pd_o), .pd_pad_oe(pd_oe), .pc_periph_sel(sel),
        .pc_periph_out(pout), .pc_periph_oe(poe), .slave_drive_en(drv_en),
        .slave_input_full(in_full), .slave_output_full(out_full),
        .slave_input_overflow(in_ovf), .slave_overflow_clear(clr),
        .parallel_slave_mode_select(mode), .port_e_dir(edir),
        .slave_bus_data(sbus), .timer_ext_clock_input(fn[0]),
        .timer_osc_input(fn[1]), .capture_compare_pwm_two(fn[2]),
        .capture_compare_pwm_one(fn[3]), .serial_clock_in(fn[4]),
        .serial_port_data_in(fn[5]), .usart_clock_in(fn[6]),
        .usart_receive_in(fn[7]));
    pcd_pin_world c_pins_i (.pad_o(pc_o), .pad_oe(pc_oe), .ext_val(c_ext),
        .ext_en(c_en), .pad_i(pc_i));
    pcd_pin_world d_pins_i (.pad_o(pd_o), .pad_oe(pd_oe), .ext_val(d_ext),
        .ext_en(d_en), .pad_i(pd_i));

    task automatic end_sim();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; waits for ack, takes data at the ack edge only
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= 4'hf;
        wb_dat <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50) chk(8'h01, 8'h00);
    endtask : wb

    // let combinational pads and one-flop pin samples settle
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    task automatic t_reset();
        settle();
        chk(pc_oe, 8'h00);
        chk(pd_oe, 8'h00);
        wb(0, IDX_PORT_C_DIR, 8'h00);
        chk(q, 8'hff);
        wb(0, IDX_PORT_D_DIR, 8'h00);
        chk(q, 8'hff);
        wb(0, IDX_PORT_E_STAT, 8'h00);
        chk(q, 8'h07);
        wb(0, 8'h10, 8'h00);
        chk(q, 8'h00);
    endtask : t_reset

    // latch versus peripheral per pin, with and without port drive
    task automatic t_port_c();
        wb(1, IDX_PORT_C_DATA, 8'ha5);
        wb(1, IDX_PORT_C_DIR, 8'h0f);
        settle();
        chk(pc_o, 8'ha5);
        chk(pc_oe, 8'hf0);
        @(posedge clk_sys);
        c_en <= 1'b1;
        c_ext <= 8'h3c;
        settle();
        // high nibble is driven by the latch, low nibble from outside
        wb(0, IDX_PORT_C_DATA, 8'h00);
        chk(q, (8'ha5 & 8'hf0) | (8'h3c & 8'h0f));
        sel <= 8'h3c;
        pout <= 8'h5a;
        poe <= 8'h0d;
        settle();
        chk(pc_o, (8'h3c & 8'h5a) | (8'hc3 & 8'ha5));
        chk(pc_oe, (8'h3c & 8'h0d) | (8'hc3 & 8'hf0));
        @(posedge clk_sys);
        sel <= 8'h00;
        wb(1, IDX_PORT_C_DIR, 8'hff);
        settle();
        chk(pc_oe, 8'h00);
    endtask : t_port_c

    // each alternate input follows its own pin
    task automatic t_functions();
        logic [7:0] p [2];
        logic [7:0] v;
        p[0] = 8'ha5;
        p[1] = 8'h5a;
        for (int i = 0; i < 2; i++) begin
            v = p[i];
            @(posedge clk_sys);
            c_ext <= v;
            settle();
            chk({4'h0, fn[3:0]}, {4'h0, v[2:1], v[1:0]});
            chk({6'h0, fn[5:4]}, {6'h0, v[4:3]});
            chk({6'h0, fn[7:6]}, {6'h0, v[7:6]});
        end
    endtask : t_functions

    // port d direction, slave mode takeover and return
    task automatic t_port_d();
        wb(1, IDX_PORT_D_DATA, 8'hc3);
        wb(1, IDX_PORT_D_DIR, 8'hf0);
        settle();
        chk(pd_oe, 8'h0f);
        chk(pd_o, 8'hc3);
        @(posedge clk_sys);
        in_full <= 1'b1;
        in_ovf <= 1'b1;
        wb(1, IDX_PORT_E_STAT, 8'h17);
        wb(1, IDX_PORT_D_DIR, 8'h00);
        settle();
        chk({7'h0, mode}, 8'h01);
        chk(pd_oe, 8'h00);
        @(posedge clk_sys);
        drv_en <= 1'b1;
        settle();
        chk(pd_oe, 8'hff);
        chk(pd_o, 8'hc3);
        wb(0, IDX_PORT_E_STAT, 8'h00);
        chk(q, 8'hb7);
        drv_en <= 1'b0;
        d_en <= 1'b1;
        d_ext <= 8'h81;
        settle();
        chk(sbus, 8'h81);
        wb(0, IDX_PORT_D_DATA, 8'h00);
        chk(q, 8'h81);
        // overflow bit written as one must not pulse the clear
        wb(1, IDX_PORT_E_STAT, 8'h23);
        settle();
        chk({5'h0, edir}, 8'h03);
        chk(pd_oe, 8'hff);
        chk(n_clr[7:0], 8'h01);
    endtask : t_port_d

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_port_c();
        t_functions();
        t_port_d();
        end_sim();
    end

    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule : testbench
